/* File: src/pmc_pkg.sv */
// Package: register map, field positions and reset values of the power mode control block
package pmc_pkg;
    // Register addresses (nibble-wide I/O space)
    localparam logic [15:0] PMC_ADDR_SUPPLY = 16'hff00;
    localparam logic [15:0] PMC_ADDR_LCD = 16'hff60;
    // Supply control fields
    localparam int PMC_BIT_LOGIC_SEL = 0;
    localparam int PMC_BIT_FAST_REG = 1;
    localparam int PMC_BIT_SLOW_HALVER = 2;
    localparam int PMC_BIT_LCD_HALVER = 3;
    // LCD control fields
    localparam int PMC_BIT_LCD_ON = 0;
    localparam int PMC_BIT_LCD_STATIC = 1;
    localparam int PMC_BIT_DUTY_LO = 2;
    localparam int PMC_BIT_DUTY_HI = 3;
    // Values after reset
    localparam logic [3:0] PMC_SUPPLY_RST = 4'h0;
    localparam logic [3:0] PMC_LCD_RST = 4'h0;
    localparam logic PMC_BIT_RST = 1'h0;
    localparam logic [3:0] PMC_UNMAPPED_RD = 4'h0;
endpackage : pmc_pkg

/* File: src/pmc_ctrl_bit.sv */
// One stored control bit with write strobe and synchronous reset
`timescale 1ns/10ps
module pmc_ctrl_bit (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic wr_i,
    input wire logic wdata_i,
    output logic q_o
);
    // Bit loads on the edge that completes the write
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            q_o <= pmc_pkg::PMC_BIT_RST;
        end else if (wr_i) begin
            q_o <= wdata_i;
        end
    end
endmodule : pmc_ctrl_bit

/* File: src/pmc_top.sv */
// Power mode control: supply and LCD power control registers
// Notes for users of this block
// The bits only store what software writes; no ordering is enforced here.
// Illegal pairs, such as a halver with the high-speed voltage, pass straight through.
// Software sequencing and the long settle waits are therefore the firmware's duty.
// Both nibbles clear on reset, so the chip wakes on the slow, low-voltage path.
// Read data are registered: they stand only in the cycle after the read strobe.
// Every other cycle the read port shows zero, so a stale value is never seen.
// Unmapped addresses read as zero and ignore writes.
// All four bits of a nibble are written together; there is no bit mask.
// The LCD duty and static bits are only stored here; the LCD driver uses them.
// One flop per bit keeps each control free of every other control.
`timescale 1ns/10ps
module pmc_top (
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    input wire logic [15:0] ADDR_I,
    input wire logic [3:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [3:0] RDATA_O,
    output logic LOGIC_SUPPLY_SELECT_O,
    output logic FAST_REGULATOR_ON_O,
    output logic SLOW_REGULATOR_HALVER_O,
    output logic LCD_SUPPLY_HALVER_O,
    output logic LCD_SUPPLY_ON_O,
    output logic LCD_STATIC_SELECT_O,
    output logic LCD_DUTY_SEL_LO_O,
    output logic LCD_DUTY_SEL_HI_O
);
    // Address matches, shared by both strobes
    logic sel_supply;
    logic sel_lcd;

    // Strobe decodes, one per register and direction
    logic wr_supply;
    logic wr_lcd;
    logic rd_supply;
    logic rd_lcd;

    // Stored nibbles and the next read value
    logic [3:0] supply_q;
    logic [3:0] lcd_q;
    logic [3:0] rdata_d;

    // Address compare against the two mapped nibbles
    assign sel_supply = (ADDR_I == pmc_pkg::PMC_ADDR_SUPPLY);
    assign sel_lcd = (ADDR_I == pmc_pkg::PMC_ADDR_LCD);

    // Writes elsewhere are ignored, so a stray store cannot move a supply
    assign wr_supply = WR_I && sel_supply;
    assign wr_lcd = WR_I && sel_lcd;

    // Reads elsewhere fall through to the unmapped value
    assign rd_supply = RD_I && sel_supply;
    assign rd_lcd = RD_I && sel_lcd;

    // Core voltage select: 1 picks the high-speed voltage
    pmc_ctrl_bit u_logic_sel (
        .clk_i(CLK_SYS_I),
        .nrst_i(NRST_I),
        .wr_i(wr_supply),
        .wdata_i(WDATA_I[pmc_pkg::PMC_BIT_LOGIC_SEL]),
        .q_o(supply_q[pmc_pkg::PMC_BIT_LOGIC_SEL])
    );

    // Fast regulator enable; off after reset to save current
    pmc_ctrl_bit u_fast_reg (
        .clk_i(CLK_SYS_I),
        .nrst_i(NRST_I),
        .wr_i(wr_supply),
        .wdata_i(WDATA_I[pmc_pkg::PMC_BIT_FAST_REG]),
        .q_o(supply_q[pmc_pkg::PMC_BIT_FAST_REG])
    );

    // Slow regulator halver; its own flop, so it never follows the LCD halver
    pmc_ctrl_bit u_slow_halver (
        .clk_i(CLK_SYS_I),
        .nrst_i(NRST_I),
        .wr_i(wr_supply),
        .wdata_i(WDATA_I[pmc_pkg::PMC_BIT_SLOW_HALVER]),
        .q_o(supply_q[pmc_pkg::PMC_BIT_SLOW_HALVER])
    );

    // LCD supply halver; independent of the slow regulator halver
    pmc_ctrl_bit u_lcd_halver (
        .clk_i(CLK_SYS_I),
        .nrst_i(NRST_I),
        .wr_i(wr_supply),
        .wdata_i(WDATA_I[pmc_pkg::PMC_BIT_LCD_HALVER]),
        .q_o(supply_q[pmc_pkg::PMC_BIT_LCD_HALVER])
    );

    // LCD supply on; low grounds every drive voltage
    pmc_ctrl_bit u_lcd_on (
        .clk_i(CLK_SYS_I),
        .nrst_i(NRST_I),
        .wr_i(wr_lcd),
        .wdata_i(WDATA_I[pmc_pkg::PMC_BIT_LCD_ON]),
        .q_o(lcd_q[pmc_pkg::PMC_BIT_LCD_ON])
    );

    // Static drive select, only stored for the LCD driver
    pmc_ctrl_bit u_lcd_static (
        .clk_i(CLK_SYS_I),
        .nrst_i(NRST_I),
        .wr_i(wr_lcd),
        .wdata_i(WDATA_I[pmc_pkg::PMC_BIT_LCD_STATIC]),
        .q_o(lcd_q[pmc_pkg::PMC_BIT_LCD_STATIC])
    );

    // Duty select, low bit
    pmc_ctrl_bit u_duty_lo (
        .clk_i(CLK_SYS_I),
        .nrst_i(NRST_I),
        .wr_i(wr_lcd),
        .wdata_i(WDATA_I[pmc_pkg::PMC_BIT_DUTY_LO]),
        .q_o(lcd_q[pmc_pkg::PMC_BIT_DUTY_LO])
    );

    // Duty select, high bit
    pmc_ctrl_bit u_duty_hi (
        .clk_i(CLK_SYS_I),
        .nrst_i(NRST_I),
        .wr_i(wr_lcd),
        .wdata_i(WDATA_I[pmc_pkg::PMC_BIT_DUTY_HI]),
        .q_o(lcd_q[pmc_pkg::PMC_BIT_DUTY_HI])
    );

    // Core voltage select straight from its flop; low after reset
    assign LOGIC_SUPPLY_SELECT_O = supply_q[pmc_pkg::PMC_BIT_LOGIC_SEL];

    // Fast regulator enable straight from its flop; off after reset
    assign FAST_REGULATOR_ON_O = supply_q[pmc_pkg::PMC_BIT_FAST_REG];

    // Slow halver straight from its flop; normal mode after reset
    assign SLOW_REGULATOR_HALVER_O = supply_q[pmc_pkg::PMC_BIT_SLOW_HALVER];

    // LCD halver straight from its flop; normal mode after reset
    assign LCD_SUPPLY_HALVER_O = supply_q[pmc_pkg::PMC_BIT_LCD_HALVER];

    // LCD supply on straight from its flop; off after reset
    assign LCD_SUPPLY_ON_O = lcd_q[pmc_pkg::PMC_BIT_LCD_ON];

    // Static select for the LCD driver
    assign LCD_STATIC_SELECT_O = lcd_q[pmc_pkg::PMC_BIT_LCD_STATIC];

    // Duty select, low bit, for the LCD driver
    assign LCD_DUTY_SEL_LO_O = lcd_q[pmc_pkg::PMC_BIT_DUTY_LO];

    // Duty select, high bit, for the LCD driver
    assign LCD_DUTY_SEL_HI_O = lcd_q[pmc_pkg::PMC_BIT_DUTY_HI];

    // Read mux; unmapped addresses and idle cycles read zero
    always_comb begin
        rdata_d = pmc_pkg::PMC_UNMAPPED_RD;
        if (rd_supply) begin
            rdata_d = supply_q;
        end else if (rd_lcd) begin
            rdata_d = lcd_q;
        end
    end

    // Read data registered: valid only in the cycle after the strobe
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            RDATA_O <= pmc_pkg::PMC_UNMAPPED_RD;
        end else begin
            RDATA_O <= rdata_d;
        end
    end
endmodule : pmc_top

/* File: testbench/pmc_properties.sv */
// Checker: port-level timing of the power control bits
`timescale 1ns/10ps
module pmc_checker (
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    input wire logic [15:0] ADDR_I,
    input wire logic [3:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [3:0] RDATA_O,
    input wire logic LOGIC_SUPPLY_SELECT_O,
    input wire logic FAST_REGULATOR_ON_O,
    input wire logic SLOW_REGULATOR_HALVER_O,
    input wire logic LCD_SUPPLY_HALVER_O,
    input wire logic LCD_SUPPLY_ON_O,
    input wire logic LCD_STATIC_SELECT_O,
    input wire logic LCD_DUTY_SEL_LO_O,
    input wire logic LCD_DUTY_SEL_HI_O
);
    // Supply nibble as seen on the outputs, and both write decodes
    wire logic [3:0] sup = {LCD_SUPPLY_HALVER_O, SLOW_REGULATOR_HALVER_O,
        FAST_REGULATOR_ON_O, LOGIC_SUPPLY_SELECT_O};
    wire logic ws = WR_I && ADDR_I == pmc_pkg::PMC_ADDR_SUPPLY;
    wire logic wl = WR_I && ADDR_I == pmc_pkg::PMC_ADDR_LCD;
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!NRST_I);
    a_core_sel: assert property (ws |=> LOGIC_SUPPLY_SELECT_O == $past(WDATA_I[0]))
        else $error("core voltage select wrong");
    a_fast_reg: assert property (ws |=> FAST_REGULATOR_ON_O == $past(WDATA_I[1]))
        else $error("fast regulator bit wrong");
    a_slow_halver: assert property (ws |=> SLOW_REGULATOR_HALVER_O == $past(WDATA_I[2]))
        else $error("slow halver bit wrong");
    a_lcd_halver: assert property (ws |=> LCD_SUPPLY_HALVER_O == $past(WDATA_I[3]))
        else $error("lcd halver bit wrong");
    a_lcd_power: assert property (wl |=> LCD_SUPPLY_ON_O == $past(WDATA_I[0]))
        else $error("lcd power bit wrong");
    a_hold_idle: assert property (!WR_I |=> $stable(sup) && $stable(LCD_SUPPLY_ON_O))
        else $error("control bit moved without write");
    a_supply_read: assert property (RD_I && ADDR_I == 16'hff00 |=> RDATA_O == $past(sup))
        else $error("supply read data wrong");
    a_reset_clear: assert property (disable iff (1'b0) !NRST_I |=> sup == 4'h0 && !LCD_SUPPLY_ON_O)
        else $error("outputs not cleared by reset");
endmodule : pmc_checker
bind pmc_top pmc_checker i_pmc_checker (.*);

/* File: testbench/tb_pmc_top.sv */
// Testbench: random and corner register traffic for the power control block
`timescale 1ns/10ps
module tb_pmc_top;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [3:0] wd = 4'h0, rdat, sup = 4'h0, lcd = 4'h0;
    logic [7:0] outs;
    logic [15:0] ra;
    logic [3:0] rdv;
    localparam int WAIT_VOLT = 25000; // 2.5 ms at 100 ns
    localparam int WAIT_OSC = 50000; // 5 ms at 100 ns
    int errors = 0, tests_run = 0;
    pmc_top i_pmc_top (.CLK_SYS_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wd), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdat), .LOGIC_SUPPLY_SELECT_O(outs[0]), .FAST_REGULATOR_ON_O(outs[1]),
        .SLOW_REGULATOR_HALVER_O(outs[2]), .LCD_SUPPLY_HALVER_O(outs[3]), .LCD_SUPPLY_ON_O(outs[4]),
        .LCD_STATIC_SELECT_O(outs[5]), .LCD_DUTY_SEL_LO_O(outs[6]), .LCD_DUTY_SEL_HI_O(outs[7]));
    task chk(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want) begin
            errors++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask : chk
    // Keep random supply writes inside the software ordering rules
    function automatic logic [3:0] legal_sup(input logic [3:0] cur, input logic [3:0] d);
        logic [3:0] r;
        r = d;
        if (cur[2]) r[0] = 1'b0;
        if (cur[0] || r[0]) r[3:2] = 2'b00;
        return r;
    endfunction : legal_sup
    // Write then read back; unmapped places read as zero
    task wr_rd(input logic [15:0] a, input logic [3:0] d);
        @(posedge clk) {addr, wd, wr} <= {a, d, 1'b1};
        if (a == pmc_pkg::PMC_ADDR_SUPPLY) sup = d;
        if (a == pmc_pkg::PMC_ADDR_LCD) lcd = d;
        @(posedge clk) {wr, rd} <= 2'b01;
        @(posedge clk) rd <= 1'b0;
        @(negedge clk);
        chk(rdat, a == 16'hff00 ? sup : a == 16'hff60 ? lcd : 4'h0);
        chk(outs, {lcd, sup});
        @(negedge clk) chk(rdat, 4'h0);
    endtask : wr_rd
    task results();
        $display("tests %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    initial begin
        forever #50 clk = ~clk;
    end
    initial begin
        void'($urandom(32'hc2c1));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk) chk(outs, 8'h00);
        // Each halver alone, then both, then none, shows the halver bits are independent
        wr_rd(16'hff00, 4'h4);
        wr_rd(16'hff00, 4'h8);
        wr_rd(16'hff00, 4'hc);
        wr_rd(16'hff00, 4'h0);
        $display("test single bits done");
        for (int i = 0; i < 300; i++) begin
            ra = i % 3 == 0 ? 16'($urandom) : i % 3 == 1 ? 16'hff00 : 16'hff60;
            rdv = 4'($urandom);
            wr_rd(ra, ra == 16'hff00 ? legal_sup(sup, rdv) : rdv);
        end
        $display("test random done");
        // Fast entry: halvers off, regulator on, then high-speed voltage
        wr_rd(16'hff00, 4'h0);
        wr_rd(16'hff00, 4'h2);
        wr_rd(16'hff00, 4'h3);
        repeat (WAIT_VOLT) @(posedge clk);
        // Oscillator start and clock switch live outside this block
        repeat (WAIT_OSC) @(posedge clk);
        @(negedge clk) chk(outs[3:0], 4'h3);
        // Back to slow, oscillator already stopped, then halver
        wr_rd(16'hff00, 4'h2);
        wr_rd(16'hff00, 4'h0);
        wr_rd(16'hff00, 4'h4);
        // LCD on, display not relied upon; contrast kept at 6 or below elsewhere
        wr_rd(16'hff60, 4'h1);
        wr_rd(16'hff00, 4'hc);
        $display("test sequences done");
        @(posedge clk) nrst <= 1'b0;
        @(posedge clk) nrst <= 1'b1;
        {sup, lcd} = 8'h00;
        @(negedge clk) chk(outs, 8'h00);
        chk(rdat, 4'h0);
        $display("test reset done");
        results();
    end
endmodule : tb_pmc_top
